// ===== logic/swc_sleep_wake.sv
// sleep and wake controller for a small microcontroller core
// assumes the core gives one-cycle sleep and watchdog-clear pulses and
// halts while coreRun is low; pins arrive asynchronously
`timescale 1ns/10ps
module swc_sleep_wake #(
  parameter int unsigned WDT_CYCLES = swc_pkg::WDT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wdtEnable,
  input wire logic [1:0] oscMode,
  input wire logic sleepExec,
  input wire logic clrWdtExec,
  input wire logic [swc_pkg::PC_W-1:0] corePc,
  input wire swc_pkg::swc_pins_t corePins,
  input wire logic masterResetPinN,
  input wire logic extIrqPin,
  input wire logic [3:0] portBPins,
  input wire logic [swc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [swc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [swc_pkg::DATA_W-1:0] regRdata,
  output swc_pkg::swc_pins_t padDrive,
  output logic masterResetPinOeN,
  output logic oscDriverOn,
  output logic coreRun,
  output logic resumeStep,
  output logic deviceReset,
  output logic prefetchReq,
  output logic [swc_pkg::PC_W-1:0] prefetchAddr,
  output logic vectorReq,
  output logic stackPush,
  output logic [swc_pkg::PC_W-1:0] vectorAddr
);

  // assertion bound: last count of the start-up wait
  localparam int OST_LAST = int'(swc_pkg::OST_CYC) - 1;

  swc_pkg::swc_state_t state, next_state;
  logic [5:0] pinRaw, syncA, syncB, syncC, pinLevel, prevLevel;
  logic [7:0] ctrl;
  logic extFlag, pchgFlag, powerDownFlagN, timeoutFlagN;
  logic [swc_pkg::OST_W-1:0] ostCnt;
  logic wdtTimeout, wdtClear, irqPending, masterLow, oscIsRc;
  logic extEdge, pchgEdge, global_irq_enable, wakeAny;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  // raw pins in synchroniser order: reset pin, interrupt pin, port 7..4
  assign pinRaw = {portBPins, extIrqPin, masterResetPinN};

  // three stages; a level is taken once stages two and three agree
  generate
    for (genvar i = 0; i < 6; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          syncA[i] <= swc_pkg::SYNC_RESET[i];
          syncB[i] <= swc_pkg::SYNC_RESET[i];
          syncC[i] <= swc_pkg::SYNC_RESET[i];
          pinLevel[i] <= swc_pkg::SYNC_RESET[i];
          prevLevel[i] <= swc_pkg::SYNC_RESET[i];
        end else begin
          syncA[i] <= pinRaw[i];
          syncB[i] <= syncA[i];
          syncC[i] <= syncB[i];
          if (syncB[i] == syncC[i]) begin
            pinLevel[i] <= syncC[i];
          end
          prevLevel[i] <= pinLevel[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------

  // edge detection and wake qualification
  assign masterLow = !pinLevel[0];
  assign extEdge = ctrl[swc_pkg::CTRL_EDGE_SEL] ? (pinLevel[1] && !prevLevel[1])
                                                 : (!pinLevel[1] && prevLevel[1]);
  assign pchgEdge = |(pinLevel[5:2] ^ prevLevel[5:2]);
  assign global_irq_enable = ctrl[swc_pkg::CTRL_GIE];
  assign irqPending = (ctrl[swc_pkg::CTRL_EXT_EN] && extFlag)
                   || (ctrl[swc_pkg::CTRL_PCHG_EN] && pchgFlag);
  assign oscIsRc = (oscMode == swc_pkg::OSC_RC);
  assign wakeAny = masterLow || wdtTimeout || irqPending;

  // watchdog cleared by clear, sleep and any wake from sleep
  assign wdtClear = (state == swc_pkg::SWC_RUN && (sleepExec || clrWdtExec))
                 || (state == swc_pkg::SWC_SLEEP && next_state != swc_pkg::SWC_SLEEP);

  swc_watchdog #(
    .PERIOD(WDT_CYCLES)
  ) u_watchdog (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .enable(wdtEnable),
    .clear(wdtClear),
    .timeout(wdtTimeout)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------

  // next state of the sleep sequence
  always_comb begin
    next_state = state;
    if (masterLow) begin
      next_state = swc_pkg::SWC_RUN;
    end else begin
      case (state)
        swc_pkg::SWC_RUN: begin
          if (sleepExec) begin
            if (irqPending) begin
              next_state = oscIsRc ? swc_pkg::SWC_RESUME : swc_pkg::SWC_OST;
            end else begin
              next_state = swc_pkg::SWC_SLEEP;
            end
          end else if (global_irq_enable && irqPending) begin
            next_state = swc_pkg::SWC_VECT;
          end
        end
        swc_pkg::SWC_SLEEP: begin
          if (wdtTimeout || irqPending) begin
            next_state = oscIsRc ? swc_pkg::SWC_RESUME : swc_pkg::SWC_OST;
          end
        end
        swc_pkg::SWC_OST: begin
          if (ostCnt == swc_pkg::OST_W'(swc_pkg::OST_CYC - 1)) begin
            next_state = swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_RESUME: begin
          next_state = global_irq_enable ? swc_pkg::SWC_VECT : swc_pkg::SWC_RUN;
        end
        swc_pkg::SWC_VECT: begin
          next_state = swc_pkg::SWC_RUN;
        end
        default: begin
          next_state = swc_pkg::SWC_RUN;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= swc_pkg::SWC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // oscillator start-up counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ostCnt <= '0;
    end else if (state == swc_pkg::SWC_OST) begin
      ostCnt <= ostCnt + 1'b1;
    end else begin
      ostCnt <= '0;
    end
  end

  // ----------------------------------------------------------------
  // core-facing outputs
  // ----------------------------------------------------------------

  // oscillator, run and step controls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oscDriverOn <= 1'b1;
      coreRun <= 1'b1;
      resumeStep <= 1'b0;
      vectorReq <= 1'b0;
      stackPush <= 1'b0;
      vectorAddr <= swc_pkg::IRQ_VECTOR;
    end else begin
      oscDriverOn <= (next_state != swc_pkg::SWC_SLEEP);
      coreRun <= (next_state == swc_pkg::SWC_RUN) || (next_state == swc_pkg::SWC_RESUME)
              || (next_state == swc_pkg::SWC_VECT);
      resumeStep <= (next_state == swc_pkg::SWC_RESUME);
      vectorReq <= (next_state == swc_pkg::SWC_VECT);
      stackPush <= (next_state == swc_pkg::SWC_VECT);
      vectorAddr <= swc_pkg::IRQ_VECTOR;
    end
  end

  // next-address prefetch while sleep executes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prefetchReq <= 1'b0;
      prefetchAddr <= '0;
    end else begin
      prefetchReq <= (state == swc_pkg::SWC_RUN) && sleepExec && !masterLow;
      if (state == swc_pkg::SWC_RUN && sleepExec) begin
        prefetchAddr <= corePc + 1'b1;
      end
    end
  end

  // reset request: reset pin, or watchdog time-out while running
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      deviceReset <= 1'b0;
    end else begin
      deviceReset <= masterLow || (state == swc_pkg::SWC_RUN && wdtTimeout);
    end
  end

  // the reset pin is input only; watchdog resets stay internal
  assign masterResetPinOeN = 1'b1;

  // pins follow the core while it runs, frozen otherwise
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      padDrive.level <= 8'h00;
      padDrive.oeN <= 8'hff;
    end else if (coreRun && next_state != swc_pkg::SWC_SLEEP) begin
      padDrive <= corePins;
    end
  end

  // ----------------------------------------------------------------
  // flags and registers
  // ----------------------------------------------------------------

  // power-down and time-out flags
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      powerDownFlagN <= 1'b1;
      timeoutFlagN <= 1'b1;
    end else begin
      // a sleep clears the power-down flag unless the reset pin is low, even beside a time-out
      if (state == swc_pkg::SWC_RUN && sleepExec && !masterLow) begin
        powerDownFlagN <= 1'b0;
      end else if (state == swc_pkg::SWC_RUN && clrWdtExec) begin
        powerDownFlagN <= 1'b1;
      end
      // a time-out wins over a sleep or clear in the same cycle
      if (wdtTimeout) begin
        timeoutFlagN <= 1'b0;
      end else if (state == swc_pkg::SWC_RUN
                   && ((sleepExec && !masterLow) || clrWdtExec)) begin
        timeoutFlagN <= 1'b1;
      end
    end
  end

  // interrupt flags: an edge wins over a software clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      extFlag <= 1'b0;
      pchgFlag <= 1'b0;
    end else begin
      if (extEdge) begin
        extFlag <= 1'b1;
      end else if (regWrite && regAddr == swc_pkg::REG_FLAGS && !regWdata[swc_pkg::FLAG_EXT]) begin
        extFlag <= 1'b0;
      end
      if (pchgEdge) begin
        pchgFlag <= 1'b1;
      end else if (regWrite && regAddr == swc_pkg::REG_FLAGS
                   && !regWdata[swc_pkg::FLAG_PCHG]) begin
        pchgFlag <= 1'b0;
      end
    end
  end

  // control register; taking the vector clears global enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= swc_pkg::CTRL_RESET;
    end else begin
      if (regWrite && regAddr == swc_pkg::REG_CTRL) begin
        ctrl <= {4'h0, regWdata[3:0]};
      end
      if (next_state == swc_pkg::SWC_VECT) begin
        ctrl[swc_pkg::CTRL_GIE] <= 1'b0;
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRead) begin
      case (regAddr)
        swc_pkg::REG_CTRL: regRdata <= ctrl;
        swc_pkg::REG_FLAGS: regRdata <= {6'h00, pchgFlag, extFlag};
        swc_pkg::REG_STATUS: regRdata <= {3'h0, state, timeoutFlagN, powerDownFlagN};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  sequence s_sleep_taken;
    state == swc_pkg::SWC_RUN && sleepExec && !masterLow && !irqPending;
  endsequence

  sequence s_asleep_quiet;
    state == swc_pkg::SWC_SLEEP && !wakeAny;
  endsequence

  a_sleep_entry_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_sleep_taken |=> !powerDownFlagN && !oscDriverOn && state == swc_pkg::SWC_SLEEP)
    else $error("sleep entry did not clear power flag or stop oscillator");

  a_pins_held_sleep: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_SLEEP ##1 state == swc_pkg::SWC_SLEEP |-> $stable(padDrive))
    else $error("pin drive changed during sleep");

  a_wake_sources_only: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_asleep_quiet |=> state == swc_pkg::SWC_SLEEP)
    else $error("left sleep without a wake event");

  a_wdt_wake_continue: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_SLEEP && wdtTimeout && !masterLow
      |=> !deviceReset && !timeoutFlagN && state != swc_pkg::SWC_SLEEP)
    else $error("watchdog wake reset the device or kept time-out flag");

  a_run_wdt_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_RUN && wdtTimeout |=> deviceReset && masterResetPinOeN)
    else $error("watchdog time-out while running gave no internal reset");

  a_prefetch_next: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_RUN && sleepExec && !masterLow
      |=> prefetchReq && prefetchAddr == $past(corePc) + 1'b1)
    else $error("prefetch of next address missing");

  a_pending_no_sleep: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_RUN && sleepExec && irqPending && !masterLow
      |=> state != swc_pkg::SWC_SLEEP ##1 state != swc_pkg::SWC_SLEEP)
    else $error("pending enabled interrupt did not wake at once");

  a_ost_length: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_RESUME && $past(state) == swc_pkg::SWC_OST
      |-> $past(ostCnt) == OST_LAST)
    else $error("oscillator start-up wait has the wrong length");

  a_rc_no_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_SLEEP && oscIsRc && irqPending && !masterLow
      |=> state == swc_pkg::SWC_RESUME ##1 coreRun)
    else $error("RC mode did not resume without delay");

  a_inline_or_vector: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_RESUME && !masterLow
      |=> vectorReq == $past(global_irq_enable))
    else $error("resume step chose the wrong continuation");

  a_vector_clears_gie: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(vectorReq) |-> stackPush && vectorAddr == swc_pkg::IRQ_VECTOR && !global_irq_enable)
    else $error("vector taken without push, address or enable clear");

  a_wake_clears_wdt: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == swc_pkg::SWC_SLEEP ##1 state != swc_pkg::SWC_SLEEP |-> $past(wdtClear))
    else $error("watchdog not cleared on wake");

endmodule : swc_sleep_wake

// ===== inc/swc_pkg.sv
// sleep/wake control package: offsets, field positions, timing, states
// assumes a 10 MHz ref_clk that keeps running while the core is halted
package swc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WDT_PERIOD_US = 18000; // nominal time-out
  localparam int unsigned WDT_CYC = WDT_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned OST_TOSC = 1024; // start-up delay in osc periods
  localparam int unsigned OST_CYC = OST_TOSC; // one ref_clk per osc period
  localparam int unsigned OST_W = 11;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam int unsigned CTRL_GIE = 0;
  localparam int unsigned CTRL_EXT_EN = 1;
  localparam int unsigned CTRL_PCHG_EN = 2;
  localparam int unsigned CTRL_EDGE_SEL = 3;
  localparam int unsigned FLAG_EXT = 0;
  localparam int unsigned FLAG_PCHG = 1;
  localparam int unsigned STAT_PD_N = 0;
  localparam int unsigned STAT_TO_N = 1;
  localparam int unsigned STAT_STATE = 2; // three bits of state
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // oscillator modes, vector, pin synchroniser
  // ----------------------------------------------------------------
  localparam logic [1:0] OSC_LP = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_HS = 2'h2;
  localparam logic [1:0] OSC_RC = 2'h3;
  localparam int unsigned PC_W = 11;
  localparam logic [10:0] IRQ_VECTOR = 11'h004;
  localparam logic [5:0] SYNC_RESET = 6'h01; // reset pin idles high

  typedef enum logic [2:0] {
    SWC_RUN = 3'h0,
    SWC_SLEEP = 3'h1,
    SWC_OST = 3'h3,
    SWC_RESUME = 3'h2,
    SWC_VECT = 3'h6
  } swc_state_t;

  // drive state of the eight port pins
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oeN;
  } swc_pins_t;

endpackage : swc_pkg

// ===== logic/swc_watchdog.sv
// watchdog counter: counts ref_clk cycles and pulses on time-out
// assumes clear and enable come from logic on the same clock
`timescale 1ns/10ps
module swc_watchdog #(
  parameter int unsigned PERIOD = swc_pkg::WDT_CYC,
  parameter int unsigned CW = $clog2(PERIOD + 1)
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic clear,
  output logic timeout
);

  logic [CW-1:0] count;

  // counter held at zero when disabled or cleared
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      timeout <= 1'b0;
    end else if (!enable || clear) begin
      count <= '0;
      timeout <= 1'b0;
    end else if (count == CW'(PERIOD - 1)) begin
      count <= '0;
      timeout <= 1'b1;
    end else begin
      count <= count + 1'b1;
      timeout <= 1'b0;
    end
  end

  a_wdt_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    !enable |=> !timeout) else $error("watchdog timed out while disabled");

  a_wdt_clear_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    clear |=> !timeout) else $error("watchdog timed out right after clear");

endmodule : swc_watchdog

// ===== bench/swc_core_model.sv
// core-side partner: issues sleep pulses and drives the pin state
// assumes coreRun from the sleep/wake block; pins keep moving while halted
`timescale 1ns/10ps
module swc_core_model (
  input wire logic ref_clk,
  input wire logic coreRun,
  input wire logic sleepReq,
  input wire logic [swc_pkg::PC_W-1:0] pcIn,
  output logic sleepExec,
  output logic [swc_pkg::PC_W-1:0] corePc,
  output swc_pkg::swc_pins_t corePins
);
  int seed = 82667;
  logic [15:0] rnd;

  // ----------------------------------------
  // sleep pulse and pin drive
  // ----------------------------------------
  initial begin
    sleepExec = 1'b0;
    corePc = '0;
    corePins = 16'h00ff;
  end

  // pins held steady around a sleep, random otherwise
  always @(posedge ref_clk) begin
    sleepExec <= sleepReq & coreRun;
    corePc <= pcIn; // word after sleep is a no-op in the modelled program
    rnd = 16'($random(seed));
    if (!sleepReq && !sleepExec) begin
      corePins <= rnd;
    end
  end
endmodule : swc_core_model

// ===== bench/swc_sleep_wake_tb_top.sv
// self-checking bench for the sleep/wake controller
// assumes the core partner model and a shortened watchdog period
`timescale 1ns/10ps
module swc_sleep_wake_tb_top;
  localparam int unsigned WDT_SIM = 50;
  int seed = 82667;
  int nErrors = 0;
  int numChecks = 0;
  int nVector = 0;
  logic ref_clk = 1'b0, resetn = 1'b0, wdtEnable = 1'b0, clrWdtExec = 1'b0;
  logic [1:0] oscMode = swc_pkg::OSC_RC;
  logic masterResetPinN = 1'b1, extIrqPin = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] portBPins = 4'h0, regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic sleepReq = 1'b0, sleepExec, rdSeen = 1'b0, lastResume = 1'b0;
  logic [10:0] pcIn = 11'h000, corePc, prefetchAddr, vectorAddr;
  swc_pkg::swc_pins_t corePins, padDrive, pinsHeld;
  logic masterResetPinOeN, oscDriverOn, coreRun, resumeStep, deviceReset;
  logic prefetchReq, vectorReq, stackPush;
  logic [7:0] expQ[$];

  swc_sleep_wake #(.WDT_CYCLES(WDT_SIM)) i_swc_sleep_wake (.ref_clk(ref_clk),
    .resetn(resetn), .wdtEnable(wdtEnable), .oscMode(oscMode), .sleepExec(sleepExec),
    .clrWdtExec(clrWdtExec), .corePc(corePc), .corePins(corePins),
    .masterResetPinN(masterResetPinN), .extIrqPin(extIrqPin), .portBPins(portBPins),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .padDrive(padDrive), .masterResetPinOeN(masterResetPinOeN),
    .oscDriverOn(oscDriverOn), .coreRun(coreRun), .resumeStep(resumeStep),
    .deviceReset(deviceReset), .prefetchReq(prefetchReq), .prefetchAddr(prefetchAddr),
    .vectorReq(vectorReq), .stackPush(stackPush), .vectorAddr(vectorAddr));
  swc_core_model i_swc_core_model (.ref_clk(ref_clk), .coreRun(coreRun),
    .sleepReq(sleepReq), .pcIn(pcIn), .sleepExec(sleepExec), .corePc(corePc),
    .corePins(corePins));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;

  function automatic logic [15:0] b(input logic v);
    return {15'h0000, v};
  endfunction : b

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    numChecks++;
    if (got !== e) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    {regAddr, regRead} <= {a, 1'b1};
    expQ.push_back(e);
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  task automatic doSleep(input logic [10:0] pc, input bit full);
    {sleepReq, pcIn} <= {1'b1, pc};
    @(posedge ref_clk);
    sleepReq <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    pinsHeld = i_swc_core_model.corePins;
    if (full) begin
      chk("prefetchReq", 16'h0001, b(prefetchReq));
      chk("prefetchAddr", {5'h00, pc + 11'h001}, {5'h00, prefetchAddr});
      chk("oscDriverOn", 16'h0000, b(oscDriverOn));
      chk("coreRun", 16'h0000, b(coreRun));
    end
    @(posedge ref_clk);
  endtask : doSleep

  task automatic waitFor(input bit rst, input int lim, output int n);
    n = 0;
    while ((rst ? deviceReset : coreRun) !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : waitFor

  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  // ----------------------------------------
  // watchers
  // ----------------------------------------
  // read data compared against the oldest note
  always @(posedge ref_clk) rdSeen <= regRead;
  always @(negedge ref_clk) begin
    if (rdSeen) begin
      chk("regRdata", {8'h00, expQ.pop_front()}, {8'h00, regRdata});
    end
  end

  // vector branch follows the resume step
  always @(posedge ref_clk) begin
    lastResume <= resumeStep;
    if (vectorReq === 1'b1) begin
      nVector++;
      chk("vectorAddr", {5'h00, swc_pkg::IRQ_VECTOR}, {5'h00, vectorAddr});
      chk("stackPush", 16'h0001, b(stackPush));
      chk("resumeFirst", 16'h0001, b(lastResume));
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    tallyAndFinish();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int n;
    logic [3:0] nib;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(swc_pkg::REG_STATUS, 8'h03);
    rd(swc_pkg::REG_CTRL, swc_pkg::CTRL_RESET);
    rd(4'h7, 8'h00);
    // watchdog wake from sleep
    wdtEnable <= 1'b1;
    doSleep(11'h123, 1'b1);
    rd(swc_pkg::REG_STATUS, 8'h06);
    repeat (10) @(posedge ref_clk);
    chk("padDrive", pinsHeld, padDrive);
    waitFor(1'b0, 80, n);
    wdtEnable <= 1'b0;
    chk("wdtWake", 16'h0001, b(n >= 20 && n < 60));
    chk("deviceReset", 16'h0000, b(deviceReset));
    rd(swc_pkg::REG_STATUS, 8'h00);
    // port-change wake in every oscillator mode, global enable off
    wr(swc_pkg::REG_CTRL, 8'h04);
    for (int m = 0; m < 4; m++) begin
      oscMode <= m[1:0];
      doSleep(11'(16 + m), 1'b1);
      nib = 4'($random(seed));
      portBPins <= portBPins ^ (nib | 4'h1);
      waitFor(1'b0, 1200, n);
      chk("ostWait", 16'h0001, b(m == 3 ? n <= 12 : n >= 1024 && n <= 1040));
      wr(swc_pkg::REG_FLAGS, 8'h00);
    end
    chk("nVector", 16'h0000, 16'(nVector));
    // enabled pin edge with global enable on
    wr(swc_pkg::REG_CTRL, 8'h0b);
    doSleep(11'h3fe, 1'b1);
    rd(swc_pkg::REG_STATUS, 8'h06);
    extIrqPin <= 1'b1;
    waitFor(1'b0, 20, n);
    repeat (4) @(posedge ref_clk);
    chk("nVector", 16'h0001, 16'(nVector));
    rd(swc_pkg::REG_CTRL, 8'h0a);
    rd(swc_pkg::REG_FLAGS, 8'h01);
    // falling edge flag, then pending flag wakes at once
    wr(swc_pkg::REG_CTRL, 8'h00);
    wr(swc_pkg::REG_FLAGS, 8'h00);
    extIrqPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(swc_pkg::REG_FLAGS, 8'h01);
    wr(swc_pkg::REG_CTRL, 8'h02);
    doSleep(11'h050, 1'b0);
    waitFor(1'b0, 12, n);
    chk("pendingWake", 16'h0001, b(n == 0 && coreRun));
    chk("nVector", 16'h0001, 16'(nVector));
    // disabled source does not wake; reset pin does
    wr(swc_pkg::REG_FLAGS, 8'h00);
    wr(swc_pkg::REG_CTRL, 8'h0d);
    doSleep(11'h060, 1'b1);
    extIrqPin <= 1'b1;
    repeat (60) @(posedge ref_clk);
    chk("coreRun", 16'h0000, b(coreRun));
    masterResetPinN <= 1'b0;
    waitFor(1'b1, 12, n);
    chk("deviceReset", 16'h0001, b(deviceReset));
    chk("resetPinOe", 16'h0001, b(masterResetPinOeN));
    masterResetPinN <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk("coreRun", 16'h0001, b(coreRun));
    rd(swc_pkg::REG_STATUS, 8'h02);
    // watchdog clear holds off the time-out; a time-out while running resets
    wdtEnable <= 1'b1;
    repeat (30) @(posedge ref_clk);
    clrWdtExec <= 1'b1;
    @(posedge ref_clk);
    clrWdtExec <= 1'b0;
    rd(swc_pkg::REG_STATUS, 8'h03);
    waitFor(1'b1, 80, n);
    chk("wdtHeldOff", 16'h0001, b(n >= 40 && n < 60));
    chk("deviceReset", 16'h0001, b(deviceReset));
    chk("resetPinOe", 16'h0001, b(masterResetPinOeN));
    rd(swc_pkg::REG_STATUS, 8'h01);
    tallyAndFinish();
  end
endmodule : swc_sleep_wake_tb_top
